// file: inc/afe_cfg_pkg.sv
package afe_cfg_pkg;
  localparam int DATA_BITS = 16;
  localparam int ADDR_BITS = 3;
  localparam int NUM_REGS = 6;
  localparam int FRAME_BITS = DATA_BITS + ADDR_BITS;

  // Register addresses
  localparam logic [2:0] REG_POWER = 3'h0;
  localparam logic [2:0] REG_RX_FILTER = 3'h1;
  localparam logic [2:0] REG_GAIN_TUNE = 3'h2;
  localparam logic [2:0] REG_RSVD_A = 3'h3;
  localparam logic [2:0] REG_RSVD_B = 3'h4;
  localparam logic [2:0] REG_DRIVER = 3'h5;

  // Field positions
  localparam int RX_OFF_IN_TX_BIT = 0;
  localparam int TX_OFF_IN_RX_BIT = 1;
  localparam int DAC_OFF_IN_RX_BIT = 2;
  localparam int CHIP_POWERDOWN_BIT = 3;
  localparam int RX_LOWPASS_BYPASS_BIT = 15;
  localparam int GAIN_LSB = 2;
  localparam int GAIN_MSB = 4;
  localparam int TUNE_CONTINUOUS_BIT = 11;
  localparam int DRIVER_SEL_LSB = 1;
  localparam int DRIVER_SEL_MSB = 2;
  localparam int TX_LOWPASS_BYPASS_BIT = 4;
  localparam int RX_HIGHPASS_DISABLE_BIT = 14;

  localparam logic [1:0] DRIVER_ACTIVE = 2'h0;
  localparam logic [1:0] DRIVER_BYP_HIGH_Z = 2'h1;
  localparam logic [1:0] DRIVER_BYP_50_OHM = 2'h3;

  // Reset patterns, index 5 down to 0
  localparam logic [NUM_REGS-1:0][DATA_BITS-1:0] REG_RESET = {
    16'hC800, 16'h0000, 16'h7ACE, 16'h7800, 16'h0008, 16'h0003
  };

  typedef enum logic [1:0] {
    PM_IDLE = 2'b00,
    PM_WRITE = 2'b01,
    PM_READ = 2'b10
  } port_mode_t;

  typedef struct packed {
    logic rx_powerdown;
    logic tx_powerdown;
    logic dac_powerdown;
    logic chip_powerdown;
    logic rx_lowpass_bypass;
    logic [2:0] predriver_gain;
    logic signed [3:0] predriver_gain_db;
    logic tune_active;
    logic [1:0] driver_bypass_sel;
    logic line_driver_active;
    logic line_driver_high_current;
    logic tx_lowpass_bypass;
    logic rx_highpass_disable;
  } afe_ctrl_t;

  typedef struct packed {
    logic [NUM_REGS-1:0][DATA_BITS-1:0] regs;
    port_mode_t mode;
    logic [FRAME_BITS-1:0] hold;
    logic [4:0] bit_cnt;
    logic [2:0] last_addr;
    logic wrote_ok;
    logic [DATA_BITS-1:0] rd_shift;
    logic [4:0] rd_cnt;
    logic sdo;
    logic sdo_oe_n;
    logic ws_prev;
    logic sclk_prev;
    afe_ctrl_t ctrl;
  } bank_state_t;
endpackage

// file: design/pin_sync.sv
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_t;

  sync_state_t s_reg;
  sync_state_t s_next;

  always_comb begin
    s_next.meta = async_in;
    s_next.stable = s_reg.meta;
    if (sys_rst) begin
      s_next = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    s_reg <= s_next;
  end

  assign sync_out = s_reg.stable;
endmodule

// file: design/afe_config_register_bank.sv
`timescale 1ns/100ps
module afe_config_register_bank (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic serial_clk,
  input wire logic write_select,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_oe_n,
  input wire logic tx_mode,
  output afe_cfg_pkg::afe_ctrl_t ctrl
);
  import afe_cfg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [3:0] pins_sync;
  logic sclk_s;
  logic ws_s;
  logic sdi_s;
  logic tx_s;

  pin_sync #(.WIDTH(4)) u_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .async_in({tx_mode, serial_data_in, write_select, serial_clk}),
    .sync_out(pins_sync)
  );

  assign {tx_s, sdi_s, ws_s, sclk_s} = pins_sync;

  function automatic logic addr_valid(input logic [2:0] a);
    return a <= REG_DRIVER;
  endfunction

  function automatic logic signed [3:0] gain_db(input logic [2:0] code);
    case (code)
      3'h0: return 4'sh3;
      3'h1: return 4'sh2;
      3'h2: return 4'sh1;
      3'h3: return 4'sh0;
      3'h4: return -4'sh1;
      3'h5: return -4'sh2;
      3'h6: return -4'sh3;
      default: return -4'sh6;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  bank_state_t s_reg;
  bank_state_t s_next;

  logic sclk_fall;
  logic ws_rise;
  logic ws_fall;
  logic commit;
  logic [2:0] commit_addr;
  logic [15:0] r_pwr;
  logic [15:0] r_rxf;
  logic [15:0] r_gt;
  logic [15:0] r_drv;

  assign sclk_fall = s_reg.sclk_prev & ~sclk_s;
  assign ws_rise = ws_s & ~s_reg.ws_prev;
  assign ws_fall = ~ws_s & s_reg.ws_prev;
  assign commit = sclk_fall && !ws_rise && !ws_fall && s_reg.mode == PM_WRITE &&
                  s_reg.bit_cnt == 5'(FRAME_BITS);
  assign commit_addr = s_reg.hold[FRAME_BITS-1:DATA_BITS];
  assign r_pwr = s_reg.regs[REG_POWER];
  assign r_rxf = s_reg.regs[REG_RX_FILTER];
  assign r_gt = s_reg.regs[REG_GAIN_TUNE];
  assign r_drv = s_reg.regs[REG_DRIVER];

  always_comb begin
    s_next = s_reg;
    s_next.ws_prev = ws_s;
    s_next.sclk_prev = sclk_s;
    if (ws_rise) begin
      s_next.mode = PM_WRITE;
      s_next.bit_cnt = '0;
      s_next.wrote_ok = 1'b0;
    end else if (ws_fall) begin
      if (s_reg.wrote_ok) begin
        s_next.mode = PM_READ;
        s_next.rd_cnt = '0;
        s_next.rd_shift = addr_valid(s_reg.last_addr) ? s_reg.regs[s_reg.last_addr] : '0;
      end else begin
        s_next.mode = PM_IDLE;
      end
    end else if (sclk_fall) begin
      case (s_reg.mode)
        PM_WRITE: begin
          if (s_reg.bit_cnt < 5'(FRAME_BITS)) begin
            s_next.hold = {sdi_s, s_reg.hold[FRAME_BITS-1:1]};
            s_next.bit_cnt = s_reg.bit_cnt + 5'h1;
          end else if (commit) begin
            if (addr_valid(commit_addr)) begin
              s_next.regs[commit_addr] = s_reg.hold[DATA_BITS-1:0];
            end
            s_next.last_addr = commit_addr;
            s_next.wrote_ok = 1'b1;
            s_next.bit_cnt = s_reg.bit_cnt + 5'h1;
          end
        end
        PM_READ: begin
          if (s_reg.rd_cnt == 5'(DATA_BITS - 1)) begin
            s_next.mode = PM_IDLE;
          end else begin
            s_next.rd_shift = {1'b0, s_reg.rd_shift[DATA_BITS-1:1]};
            s_next.rd_cnt = s_reg.rd_cnt + 5'h1;
          end
        end
        PM_IDLE: begin
          s_next.mode = PM_IDLE;
        end
        default: begin
          s_next.mode = PM_IDLE;
        end
      endcase
    end
    s_next.sdo = s_next.rd_shift[0];
    s_next.sdo_oe_n = (s_next.mode != PM_READ);

    // Control outputs follow the registers one cycle later
    s_next.ctrl.chip_powerdown = r_pwr[CHIP_POWERDOWN_BIT];
    s_next.ctrl.rx_powerdown = r_pwr[CHIP_POWERDOWN_BIT] | (r_pwr[RX_OFF_IN_TX_BIT] & tx_s);
    s_next.ctrl.tx_powerdown = r_pwr[CHIP_POWERDOWN_BIT] | (r_pwr[TX_OFF_IN_RX_BIT] & ~tx_s);
    s_next.ctrl.dac_powerdown = r_pwr[CHIP_POWERDOWN_BIT] | (r_pwr[DAC_OFF_IN_RX_BIT] & ~tx_s);
    s_next.ctrl.rx_lowpass_bypass = r_rxf[RX_LOWPASS_BYPASS_BIT];
    s_next.ctrl.predriver_gain = r_gt[GAIN_MSB:GAIN_LSB];
    s_next.ctrl.predriver_gain_db = gain_db(r_gt[GAIN_MSB:GAIN_LSB]);
    s_next.ctrl.tune_active = r_gt[TUNE_CONTINUOUS_BIT];
    s_next.ctrl.driver_bypass_sel = r_drv[DRIVER_SEL_MSB:DRIVER_SEL_LSB];
    s_next.ctrl.line_driver_active = r_drv[DRIVER_SEL_MSB:DRIVER_SEL_LSB] == DRIVER_ACTIVE;
    s_next.ctrl.line_driver_high_current =
      r_drv[DRIVER_SEL_MSB:DRIVER_SEL_LSB] == DRIVER_BYP_50_OHM;
    s_next.ctrl.tx_lowpass_bypass = r_drv[TX_LOWPASS_BYPASS_BIT];
    s_next.ctrl.rx_highpass_disable = r_drv[RX_HIGHPASS_DISABLE_BIT];

    if (sys_rst) begin
      s_next = '0;
      s_next.regs = REG_RESET;
      s_next.mode = PM_IDLE;
      s_next.sdo_oe_n = 1'b1;
      s_next.ctrl.tune_active = 1'b1;
      s_next.ctrl.tx_powerdown = 1'b1;
      s_next.ctrl.rx_highpass_disable = 1'b1;
      s_next.ctrl.line_driver_active = 1'b1;
      s_next.ctrl.predriver_gain_db = gain_db(3'h0);
    end
  end

  always_ff @(posedge sys_clk) begin
    s_reg <= s_next;
  end

  assign serial_data_out = s_reg.sdo;
  assign serial_data_oe_n = s_reg.sdo_oe_n;
  assign ctrl = s_reg.ctrl;

  ////////////////////////////////////////////////////////////////////////////
  logic want_rx_pd;
  logic want_tx_pd;
  logic want_dac_pd;
  logic [2:0] want_gain;

  assign want_rx_pd = r_pwr[CHIP_POWERDOWN_BIT] | (r_pwr[RX_OFF_IN_TX_BIT] & tx_s);
  assign want_tx_pd = r_pwr[CHIP_POWERDOWN_BIT] | (r_pwr[TX_OFF_IN_RX_BIT] & ~tx_s);
  assign want_dac_pd = r_pwr[CHIP_POWERDOWN_BIT] | (r_pwr[DAC_OFF_IN_RX_BIT] & ~tx_s);
  assign want_gain = r_gt[GAIN_MSB:GAIN_LSB];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  property p_commit_valid;
    commit && addr_valid(commit_addr) |=>
      s_reg.regs[$past(commit_addr)] == $past(s_reg.hold[DATA_BITS-1:0]);
  endproperty
  a_commit_valid: assert property (p_commit_valid) else $error("write not stored");

  property p_commit_invalid;
    commit && !addr_valid(commit_addr) |=> $stable(s_reg.regs);
  endproperty
  a_commit_invalid: assert property (p_commit_invalid) else $error("bad address wrote");

  property p_rx_pd;
    ##1 ctrl.rx_powerdown == $past(want_rx_pd);
  endproperty
  a_rx_pd: assert property (p_rx_pd) else $error("receive power-down wrong");

  property p_tx_pd;
    ##1 ctrl.tx_powerdown == $past(want_tx_pd);
  endproperty
  a_tx_pd: assert property (p_tx_pd) else $error("transmit power-down wrong");

  property p_dac_pd;
    ##1 ctrl.dac_powerdown == $past(want_dac_pd);
  endproperty
  a_dac_pd: assert property (p_dac_pd) else $error("DAC power-down wrong");

  property p_chip_pd;
    ctrl.chip_powerdown |-> ctrl.rx_powerdown && ctrl.tx_powerdown && ctrl.dac_powerdown;
  endproperty
  a_chip_pd: assert property (p_chip_pd) else $error("chip power-down incomplete");

  property p_gain;
    ##1 ctrl.predriver_gain == $past(want_gain);
  endproperty
  a_gain: assert property (p_gain) else $error("gain field not followed");

  property p_reset_vals;
    $fell(sys_rst) |-> s_reg.regs == REG_RESET && ctrl.tune_active;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset pattern wrong");

  property p_write_mode;
    ws_rise |=> s_reg.mode == PM_WRITE && s_reg.bit_cnt == 5'h0 && serial_data_oe_n;
  endproperty
  a_write_mode: assert property (p_write_mode) else $error("write mode not entered");

  property p_read_drive;
    ws_fall && s_reg.wrote_ok |=> !serial_data_oe_n ##0 serial_data_out == s_reg.rd_shift[0];
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("read not driven");

  c_commit: cover property (commit && addr_valid(commit_addr));
  c_bad_addr: cover property (commit && !addr_valid(commit_addr));
  c_read_end: cover property (s_reg.mode == PM_READ ##1 s_reg.mode == PM_IDLE);
  c_abort: cover property (ws_fall && !s_reg.wrote_ok);
endmodule

// file: bench/serial_host.sv
`timescale 1ns/100ps
module serial_host (
  input wire logic sys_clk,
  input wire logic serial_data_out,
  input wire logic serial_data_oe_n,
  output logic serial_clk,
  output logic write_select,
  output logic pin
);
  logic drv;
  initial begin
    serial_clk = 1'b1;
    write_select = 1'b0;
    drv = 1'b0;
  end
  // Device owns the data wire only while its enable is low
  assign pin = serial_data_oe_n ? drv : serial_data_out;
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Serial clock idles high and moves inside frames, read words and the three clocks after an aborted frame
  task automatic fall;
    serial_clk <= 1'b0;
    tick(4);
    serial_clk <= 1'b1;
    tick(2);
  endtask
  task automatic write_frame(input logic [2:0] addr, input logic [15:0] data);
    logic [18:0] frame;
    frame = {addr, data};
    @(posedge sys_clk);
    write_select <= 1'b1;
    tick(4);
    for (int i = 0; i < 19; i++) begin
      drv <= frame[i];
      tick(2);
      fall();
    end
    fall();
    tick(2);
  endtask
  task automatic read_word(output logic [15:0] data, output logic oe_ok);
    write_select <= 1'b0;
    // Released line shows the inverse of the last bit driven
    drv <= ~drv;
    oe_ok = 1'b1;
    tick(2);
    for (int i = 0; i < 16; i++) begin
      tick(2);
      data[i] = pin;
      oe_ok &= (serial_data_oe_n === 1'b0);
      fall();
    end
    tick(2);
    oe_ok &= (serial_data_oe_n === 1'b1);
  endtask
  // Write-select drops before the commit clock: no store and no read may follow
  task automatic abort_frame(output logic oe_seen);
    @(posedge sys_clk);
    write_select <= 1'b1;
    tick(4);
    for (int i = 0; i < 5; i++) begin
      drv <= 1'b1;
      tick(2);
      fall();
    end
    write_select <= 1'b0;
    oe_seen = 1'b0;
    repeat (3) begin
      tick(4);
      oe_seen |= (serial_data_oe_n === 1'b0);
      fall();
    end
  endtask
endmodule

// file: bench/afe_config_register_bank_bench.sv
`timescale 1ns/100ps
module afe_config_register_bank_bench;
  import afe_cfg_pkg::*;
  localparam logic [3:0] DB [0:7] = '{4'h3, 4'h2, 4'h1, 4'h0, 4'hF, 4'hE, 4'hD, 4'hA};
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic tx_mode = 1'b0;
  logic serial_clk, write_select, pin, serial_data_out, serial_data_oe_n;
  afe_ctrl_t ctrl;
  int fails = 0;
  int comparisons = 0;
  logic [15:0] regs [0:5];
  logic [15:0] rd;
  logic ok;
  always #50 sys_clk = ~sys_clk;
  afe_config_register_bank uut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .serial_clk(serial_clk), .write_select(write_select), .serial_data_in(pin),
    .serial_data_out(serial_data_out), .serial_data_oe_n(serial_data_oe_n),
    .tx_mode(tx_mode), .ctrl(ctrl));
  serial_host host (.sys_clk(sys_clk), .serial_data_out(serial_data_out),
    .serial_data_oe_n(serial_data_oe_n), .serial_clk(serial_clk),
    .write_select(write_select), .pin(pin));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic afe_ctrl_t model(input logic t);
    afe_ctrl_t c;
    logic pd;
    pd = regs[0][3];
    c.chip_powerdown = pd;
    c.rx_powerdown = pd | (regs[0][0] & t);
    c.tx_powerdown = pd | (regs[0][1] & ~t);
    c.dac_powerdown = pd | (regs[0][2] & ~t);
    c.rx_lowpass_bypass = regs[1][15];
    c.predriver_gain = regs[2][4:2];
    c.predriver_gain_db = DB[regs[2][4:2]];
    c.tune_active = regs[2][11];
    c.driver_bypass_sel = regs[5][2:1];
    c.line_driver_active = (regs[5][2:1] == 2'h0);
    c.line_driver_high_current = (regs[5][2:1] == 2'h3);
    c.tx_lowpass_bypass = regs[5][4];
    c.rx_highpass_disable = regs[5][14];
    return c;
  endfunction
  task automatic check_ctrl;
    chk(ctrl, model(tx_mode));
    tx_mode <= ~tx_mode;
    repeat (6) @(posedge sys_clk);
    chk(ctrl, model(tx_mode));
  endtask
  task automatic reset_dut;
    sys_rst <= 1'b1;
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    regs = '{16'h0003, 16'h0008, 16'h7800, 16'h7ACE, 16'h0000, 16'hC800};
    repeat (4) @(posedge sys_clk);
    check_ctrl();
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    host.write_frame(a, d);
    if (a < 3'h6) regs[a] = d;
    host.read_word(rd, ok);
    chk(rd, (a < 3'h6) ? d : 16'h0000);
    chk(ok, 1'b1);
    check_ctrl();
  endtask
  task automatic close_out;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    close_out();
  end
  initial begin
    reset_dut();
    for (int a = 0; a < 6; a++) begin
      wr(a[2:0], 16'h5AF0 ^ (a[15:0] * 16'h1111));
    end
    wr(3'h6, 16'hFFFF);
    wr(3'h7, 16'h1234);
    for (int c = 0; c < 8; c++) begin
      wr(REG_GAIN_TUNE, {4'h7, c[0], 6'h00, c[2:0], 2'h0});
    end
    for (int k = 0; k < 4; k++) begin
      wr(REG_DRIVER, {k[1], k[0], 9'h000, k[0], 1'b0, k[1:0], 1'b0});
    end
    wr(REG_RX_FILTER, 16'h8000);
    wr(REG_POWER, 16'h0004);
    wr(REG_POWER, 16'h0008);
    wr(REG_POWER, 16'h0007);
    host.abort_frame(ok);
    chk(ok, 1'b0);
    check_ctrl();
    reset_dut();
    close_out();
  end
endmodule
